// *** gpio_pkg.sv ***
// Package: register offsets, field positions, reset values and sensitivity codes
package gpio_pkg;
   localparam int unsigned data_w = 8;
   localparam int unsigned addr_w = 3;
   // Register offsets
   localparam logic [2:0] off_data_latch = 3'h0;
   localparam logic [2:0] off_direction = 3'h1;
   localparam logic [2:0] off_option = 3'h2;
   localparam logic [2:0] off_sens_config = 3'h3;
   localparam logic [2:0] off_int_group = 3'h4;
   localparam logic [2:0] off_pending = 3'h5;
   // Sensitivity configuration field positions
   localparam int unsigned pos_invert_a = 0;
   localparam int unsigned pos_sens_g0 = 1;
   localparam int unsigned pos_sens_g1 = 3;
   localparam int unsigned pos_invert_b = 5;
   localparam int unsigned pos_sens_g2 = 6;
   // Reset values
   localparam logic [7:0] rst_data_latch = 8'h00;
   localparam logic [7:0] rst_direction = 8'h00;
   localparam logic [7:0] rst_option = 8'h00;
   localparam logic [7:0] rst_sens_config = 8'h00;
   localparam logic [7:0] rst_int_group = 8'h00;
   // Sensitivity codes
   localparam logic [1:0] sens_fall_low = 2'h0;
   localparam logic [1:0] sens_rise = 2'h1;
   localparam logic [1:0] sens_fall = 2'h2;
   localparam logic [1:0] sens_both = 2'h3;
   localparam int unsigned num_groups = 3;
endpackage

// *** pin_sync.sv ***
// Two-stage synchroniser for the pin inputs
module pin_sync #(
   parameter int unsigned width = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Data
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** ext_int_group.sv ***
// One external interrupt group: qualify pins, OR them, hold the request latch
module ext_int_group #(
   parameter int unsigned width = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Pin state
   input wire logic [width-1:0] pin_now,
   input wire logic [width-1:0] pin_prev,
   input wire logic [width-1:0] src_enable,
   // Configuration
   input wire logic [1:0] sens,
   input wire logic invert,
   input wire logic sens_written,
   // CPU side
   input wire logic vector_fetch,
   output logic request_q
);
   logic [width-1:0] lvl_now;
   logic [width-1:0] lvl_prev;
   logic [width-1:0] hit;
   logic any_hit;

   // Inversion swaps polarity so one detector serves both
   assign lvl_now = invert ? ~pin_now : pin_now;
   assign lvl_prev = invert ? ~pin_prev : pin_prev;

   // Qualify each pin by the sensitivity code
   genvar i;
   for (i = 0; i < width; i++) begin : g_pin
      logic rise;
      logic fall;
      assign rise = lvl_now[i] & ~lvl_prev[i];
      assign fall = ~lvl_now[i] & lvl_prev[i];
      assign hit[i] = src_enable[i] & (
         (sens == gpio_pkg::sens_fall_low) ? ~lvl_now[i] :
         (sens == gpio_pkg::sens_rise) ? rise :
         (sens == gpio_pkg::sens_fall) ? fall : (rise | fall));
   end

   assign any_hit = |hit;

   // Request latch: new event wins over fetch and configuration clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         request_q <= 1'b0;
      end else if (any_hit) begin
         request_q <= 1'b1;
      end else if (vector_fetch || sens_written) begin
         request_q <= 1'b0;
      end
   end

   chk_fetch_clears: assert property (@(posedge clock) disable iff (sys_rst)
      (vector_fetch && !any_hit) |=> !request_q)
      else $error("request latch not cleared by vector fetch");
   chk_config_clears: assert property (@(posedge clock) disable iff (sys_rst)
      (sens_written && !any_hit) |=> !request_q)
      else $error("request latch not cleared by sensitivity write");
   chk_event_sets: assert property (@(posedge clock) disable iff (sys_rst)
      any_hit |=> request_q)
      else $error("qualified event did not set the request latch");
endmodule

// *** gpio_port.sv ***
// Eight-pin general purpose port with grouped external interrupt requests
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
module gpio_port #(
   parameter int unsigned width = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Pins
   input wire logic [width-1:0] pin_in,
   output logic [width-1:0] pin_out,
   output logic [width-1:0] pin_oe_n,
   output logic [width-1:0] pin_pullup,
   // CPU interrupt side
   input wire logic [2:0] vector_fetch,
   output logic [2:0] ext_int_req
);
   logic [width-1:0] port_data_latch_q;
   logic [width-1:0] pin_direction_q;
   logic [width-1:0] pin_option_q;
   logic [7:0] ext_int_sensitivity_config_q;
   logic [7:0] int_group_map_q;
   logic [width-1:0] pin_sync_now;
   logic [width-1:0] pin_prev_q;
   logic [width-1:0] pin_out_d;
   logic [width-1:0] pin_oe_n_d;
   logic [width-1:0] pin_pullup_d;
   logic [width-1:0] int_input;
   logic [width-1:0] read_port;
   logic [7:0] rdata_d;
   logic [2:0] req_w;
   logic sel_data;
   logic sel_dir;
   logic sel_opt;
   logic sel_sens;
   logic sel_map;
   logic sens_written;
   logic [7:0] g1_mask;
   logic [7:0] g2_mask;

   // Address decode
   assign sel_data = reg_addr == gpio_pkg::off_data_latch;
   assign sel_dir = reg_addr == gpio_pkg::off_direction;
   assign sel_opt = reg_addr == gpio_pkg::off_option;
   assign sel_sens = reg_addr == gpio_pkg::off_sens_config;
   assign sel_map = reg_addr == gpio_pkg::off_int_group;
   assign sens_written = reg_write & sel_sens;

   // Register writes; reset puts every pin in floating input
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         port_data_latch_q <= gpio_pkg::rst_data_latch;
         pin_direction_q <= gpio_pkg::rst_direction;
         pin_option_q <= gpio_pkg::rst_option;
         ext_int_sensitivity_config_q <= gpio_pkg::rst_sens_config;
         int_group_map_q <= gpio_pkg::rst_int_group;
      end else if (reg_write) begin
         if (sel_data) port_data_latch_q <= reg_wdata[width-1:0];
         if (sel_dir) pin_direction_q <= reg_wdata[width-1:0];
         if (sel_opt) pin_option_q <= reg_wdata[width-1:0];
         if (sel_sens) ext_int_sensitivity_config_q <= reg_wdata;
         if (sel_map) int_group_map_q <= reg_wdata;
      end
   end

   // Pin synchroniser
   pin_sync #(.width(width)) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(pin_in),
      .sync_out(pin_sync_now)
   );

   // Previous synchronised level for edge detection
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pin_prev_q <= '0;
      end else begin
         pin_prev_q <= pin_sync_now;
      end
   end

   // Per-pin mode decode from direction/option pair; each pin set on its own
   genvar i;
   for (i = 0; i < width; i++) begin : g_pin
      assign int_input[i] = ~pin_direction_q[i] & pin_option_q[i];
      assign pin_pullup_d[i] = ~pin_direction_q[i] & pin_option_q[i];
      // Open drain floats a one; push-pull drives both
      assign pin_oe_n_d[i] = ~pin_direction_q[i] |
         (~pin_option_q[i] & port_data_latch_q[i]);
      assign pin_out_d[i] = port_data_latch_q[i];
      assign read_port[i] = pin_direction_q[i] ? port_data_latch_q[i]
                                               : pin_sync_now[i];
   end

   // Read mux; unmapped offsets read zero
   assign rdata_d = !reg_read ? 8'h00 :
      sel_data ? 8'(read_port) :
      sel_dir ? 8'(pin_direction_q) :
      sel_opt ? 8'(pin_option_q) :
      sel_sens ? ext_int_sensitivity_config_q :
      sel_map ? int_group_map_q :
      (reg_addr == gpio_pkg::off_pending) ? {5'h00, ext_int_req} : 8'h00;

   // Group membership: map bit set puts pins 0-3 in group 1 and pins 4-7 in group 2; clear bit keeps group 0
   assign g1_mask = int_group_map_q & 8'h0f;
   assign g2_mask = int_group_map_q & 8'hf0;

   // One request latch per vector, each on its own pin set
   ext_int_group #(.width(width)) u_grp0 (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_now(pin_sync_now),
      .pin_prev(pin_prev_q),
      .src_enable(int_input & ~int_group_map_q[width-1:0]),
      .sens(ext_int_sensitivity_config_q[gpio_pkg::pos_sens_g0 +: 2]),
      .invert(ext_int_sensitivity_config_q[gpio_pkg::pos_invert_a]),
      .sens_written(sens_written),
      .vector_fetch(vector_fetch[0]),
      .request_q(req_w[0])
   );
   ext_int_group #(.width(width)) u_grp1 (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_now(pin_sync_now),
      .pin_prev(pin_prev_q),
      .src_enable(int_input & g1_mask[width-1:0]),
      .sens(ext_int_sensitivity_config_q[gpio_pkg::pos_sens_g1 +: 2]),
      .invert(1'b0),
      .sens_written(sens_written),
      .vector_fetch(vector_fetch[1]),
      .request_q(req_w[1])
   );
   ext_int_group #(.width(width)) u_grp2 (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_now(pin_sync_now),
      .pin_prev(pin_prev_q),
      .src_enable(int_input & g2_mask[width-1:0]),
      .sens(ext_int_sensitivity_config_q[gpio_pkg::pos_sens_g2 +: 2]),
      .invert(ext_int_sensitivity_config_q[gpio_pkg::pos_invert_b]),
      .sens_written(sens_written),
      .vector_fetch(vector_fetch[2]),
      .request_q(req_w[2])
   );

   // Registered outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
         pin_out <= '0;
         pin_oe_n <= '1;
         pin_pullup <= '0;
         ext_int_req <= 3'h0;
      end else begin
         reg_rdata <= rdata_d;
         pin_out <= pin_out_d;
         pin_oe_n <= pin_oe_n_d;
         pin_pullup <= pin_pullup_d;
         ext_int_req <= req_w;
      end
   end

   chk_input_no_drive: assert property (@(posedge clock) disable iff (sys_rst)
      !pin_direction_q[0] |=> pin_oe_n[0])
      else $error("input pin is being driven");
   chk_pushpull_drive: assert property (@(posedge clock) disable iff (sys_rst)
      (pin_direction_q[0] && pin_option_q[0]) |=> (!pin_oe_n[0] && pin_out[0] == $past(port_data_latch_q[0])))
      else $error("push-pull pin not driving latch");
   chk_opendrain_one: assert property (@(posedge clock) disable iff (sys_rst)
      (pin_direction_q[0] && !pin_option_q[0] && port_data_latch_q[0]) |=> pin_oe_n[0])
      else $error("open-drain one not floating");
   chk_read_input: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_read && sel_data && !pin_direction_q[1]) |=> reg_rdata[1] == $past(pin_sync_now[1]))
      else $error("input read does not return pin level");
   chk_read_output: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_read && sel_data && pin_direction_q[1]) |=> reg_rdata[1] == $past(port_data_latch_q[1]))
      else $error("output read does not return latch");
   chk_write_latch: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_write && sel_data && !pin_direction_q[2]) |=> ##1 (pin_oe_n[2] && port_data_latch_q[2] == $past(reg_wdata[2], 2)))
      else $error("write to input pin misbehaved");
   chk_pullup_mode: assert property (@(posedge clock) disable iff (sys_rst)
      int_input[3] |=> pin_pullup[3])
      else $error("pull-up not enabled in option input");
   chk_req_follows: assert property (@(posedge clock) disable iff (sys_rst)
      ##1 ext_int_req == $past(req_w))
      else $error("request output lags latch");
endmodule

// *** far_side_model.sv ***
// Far-side model: pads with an external driver, pull-ups and the CPU vector fetch
module far_side_model (
   // Clock
   input wire logic clock,
   // Pad side of the port
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] pin_pullup,
   output logic [7:0] pin_in,
   // External driver
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   // CPU side
   input wire logic [2:0] fetch_req,
   input wire logic [3:0] lag,
   input wire logic [2:0] ext_int_req,
   output logic [2:0] vector_fetch
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flt_q = 1'b0;
   logic [2:0] grp;
   // An undriven pad wanders every cycle rather than keeping its value
   always @(posedge clock) flt_q <= ~flt_q;
   // Pad level: port driver first, then external driver, then pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pin_pullup[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = flt_q ^ i[0];
         end
      end
   end
   // CPU fetches the vector of a pending request after a chosen lag
   initial vector_fetch = 3'h0;
   always @(posedge clock) begin
      if (fetch_req != 3'h0) begin
         grp = fetch_req & ext_int_req;
         repeat (lag) @(posedge clock);
         vector_fetch <= grp;
         @(posedge clock);
         vector_fetch <= 3'h0;
      end
   end
endmodule

// *** gpio_port_bench.sv ***
// Testbench for the eight-pin port: registers, pads and grouped requests against a model
module gpio_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata, pin_in, pin_out, pin_oe_n, pin_pullup, got;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_en = 8'hff;
   logic [2:0] fetch_req = 3'h0;
   logic [3:0] lag = 4'h0;
   logic [2:0] vector_fetch, ext_int_req;
   logic [15:0] lfsr = 16'hc76c;
   int num_errors = 0;
   int num_checks = 0;
   int m_latch, m_dir, m_opt, g, s, v, p, a, iv, e;

   // Clock
   initial forever #12.5 clock = ~clock;

   gpio_port #(.width(8)) gpio_port_inst (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .vector_fetch(vector_fetch),
      .ext_int_req(ext_int_req));
   far_side_model far_side_model_inst (.clock(clock), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .pin_in(pin_in), .ext_val(ext_val),
      .ext_en(ext_en), .fetch_req(fetch_req), .lag(lag), .ext_int_req(ext_int_req),
      .vector_fetch(vector_fetch));

   // Random source
   function automatic logic [15:0] lfsr_next(input logic [15:0] st);
      return {st[14:0], st[15] ^ st[13] ^ st[12] ^ st[10]};
   endfunction

   // Comparisons
   task automatic tally(input string n, input logic [7:0] ex, input logic [7:0] gt);
      num_checks++;
      if (gt !== ex) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, ex, gt);
      end
   endtask
   task automatic chk_reg(input string n, input logic [7:0] ex, input logic [7:0] gt);
      tally(n, ex, gt);
   endtask
   task automatic chk_pad(input string n, input logic [7:0] ex, input logic [7:0] gt);
      tally(n, ex, gt);
   endtask
   task automatic chk_req(input logic [2:0] ex);
      tally("ext_int_req", {5'h00, ex}, {5'h00, ext_int_req});
   endtask

   // Register bus cycles
   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [2:0] ad, output logic [7:0] d);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clock);
   endtask

   // Pad outputs and data read against the model
   task automatic check_pads;
      repeat (4) @(posedge clock);
      chk_pad("pin_oe_n", 8'(~(m_dir & (m_opt | ~m_latch))), pin_oe_n);
      chk_pad("pin_out", 8'(m_latch), pin_out);
      chk_pad("pin_pullup", 8'(~m_dir & m_opt), pin_pullup);
      rd(3'h0, got);
      chk_reg("data", 8'((m_dir & m_latch) | (~m_dir & ext_val)), got);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (8000) @(posedge clock);
      num_errors++;
      stop_test;
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      m_latch = 0;
      m_dir = 0;
      m_opt = 0;
      check_pads;
      for (int k = 1; k < 8; k++) begin
         rd(k[2:0], got);
         chk_reg("reset read", 8'h00, got);
      end
      $display("test reset done");
      // Random modes; latch written before direction
      for (int k = 0; k < 8; k++) begin
         lfsr = lfsr_next(lfsr);
         m_latch = lfsr[7:0];
         m_dir = lfsr[15:8];
         lfsr = lfsr_next(lfsr);
         m_opt = lfsr[7:0];
         ext_val <= lfsr[15:8];
         wr(3'h0, 8'(m_latch));
         wr(3'h1, 8'(m_dir));
         wr(3'h2, 8'(m_opt));
         check_pads;
         rd(3'h1, got);
         chk_reg("direction", 8'(m_dir), got);
         rd(3'h2, got);
         chk_reg("option", 8'(m_opt), got);
      end
      wr(3'h6, 8'hff);
      rd(3'h6, got);
      chk_reg("unmapped", 8'h00, got);
      $display("test modes done");
      // Interrupt groups: one pin each, pin 3 idle high beside pin 2
      m_dir = 0;
      m_latch = 0;
      ext_val <= 8'h08;
      wr(3'h1, 8'h00);
      wr(3'h4, 8'h4c);
      for (g = 0; g < 3; g++) begin
         p = (g == 0) ? 1 : (g == 1) ? 2 : 6;
         wr(3'h2, (g == 1) ? 8'h0c : 8'(1 << p));
         for (s = 0; s < 4; s++) begin
            for (v = 0; v < 2; v++) begin
               lfsr = lfsr_next(lfsr);
               a = lfsr[0];
               iv = (g != 1) ? v : 0;
               ext_val[p] <= a[0];
               repeat (6) @(posedge clock);
               // Old setting may still hit in the write cycle; the repeat clears on the new one
               wr(3'h3, 8'(s << 1 | s << 3 | s << 6 | v | v << 5));
               wr(3'h3, 8'(s << 1 | s << 3 | s << 6 | v | v << 5));
               repeat (6) @(posedge clock);
               e = (s == 0 && (a ^ iv) == 0);
               chk_req(3'(e << g));
               ext_val[p] <= ~a[0];
               repeat (6) @(posedge clock);
               e = e | (s == 3) | (s == 0 && (a ^ iv) == 1);
               e = e | (s == 1 && (a ^ iv) == 0) | (s == 2 && (a ^ iv) == 1);
               chk_req(3'(e << g));
               rd(3'h5, got);
               chk_reg("pending", 8'(e << g), got);
               lag <= lfsr[4:1];
               fetch_req <= 3'(1 << g);
               @(posedge clock);
               fetch_req <= 3'h0;
               repeat (24) @(posedge clock);
               e = (s == 0 && (a ^ iv) == 1);
               chk_req(3'(e << g));
            end
         end
      end
      $display("test interrupts done");
      stop_test;
   end
endmodule
